// *** rtl/alarm_seq_pkg.sv ***
/*
 * alarm_seq_pkg: constants, states and carrier structs for the alarm
 * dial-out sequencer.
 * Assumes a single 40 MHz clock; every interval is counted in base ticks.
 */
package alarm_seq_pkg;

    // ------------------------------------------------------------------
    // register map (word addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL       = 4'h0;  // mute, ack
    localparam logic [3:0] ADDR_PERSIST    = 4'h1;  // persistence window, ticks
    localparam logic [3:0] ADDR_PREDIAL    = 4'h2;  // pre-dial hold, ticks
    localparam logic [3:0] ADDR_INTERDIAL  = 4'h3;  // inter-dial wait, ticks
    localparam logic [3:0] ADDR_REPEAT     = 4'h4;  // message repeats per call
    localparam logic [3:0] ADDR_MAXCALLS   = 4'h5;  // dial attempt limit
    localparam logic [3:0] ADDR_NUMSEL     = 4'h6;  // selected numbers mask
    localparam logic [3:0] ADDR_STATUS     = 4'h7;  // state and counters

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MUTE_BIT = 0;   // site speaker silence
    localparam int CTRL_ACK_BIT  = 1;   // write 1: on-site acknowledge pulse

    // ------------------------------------------------------------------
    // widths, reset values and timing
    // ------------------------------------------------------------------
    localparam int          NUM_SLOTS       = 8;
    localparam int          SLOT_W          = 3;
    localparam int          TIME_W          = 16;
    localparam int          CNT_W           = 8;
    localparam logic [15:0] PERSIST_RST     = 16'h000A;
    localparam logic [15:0] PREDIAL_RST     = 16'h001E;
    localparam logic [15:0] INTERDIAL_RST   = 16'h003C;
    localparam logic [7:0]  REPEAT_RST      = 8'h03;
    localparam logic [7:0]  MAXCALLS_RST    = 8'h10;
    localparam logic [7:0]  NUMSEL_RST      = 8'h01;
    localparam logic [3:0]  RING_LIMIT      = 4'hA;      // rings before hang-up
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          TICK_MS         = 100;       // base tick period, ms
    localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int          BLINK_TICKS     = 5;         // blink half period

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_ALERT, ST_PREDIAL, ST_DIAL, ST_RING, ST_RECITE,
        ST_HANGUP, ST_WAIT, ST_DONE
    } seq_state_t;

    typedef enum logic [1:0] {LED_GREEN, LED_BLINK_GREEN, LED_BLINK_RED, LED_RED} led_mode_t;

    // line side events from the call progress detector and the voice player
    typedef struct packed {
        logic ring;       // one ring cadence ended
        logic busy;       // busy tone detected
        logic answered;   // far end picked up
        logic msg_done;   // voice player finished one message
    } line_ev_t;

    // line side commands
    typedef struct packed {
        logic                off_hook;
        logic                dial;       // pulse: dial slot
        logic [SLOT_W-1:0]   slot;
        logic                play_msg;   // pulse: recite one message
        logic                ask_ack;    // level during recitation
    } line_cmd_t;

endpackage

// *** rtl/alarm_dialout_sequencer.sv ***
/*
 * alarm_dialout_sequencer: qualifies one monitored sensor input into a
 * valid alarm and runs the pre-dial hold and telephone dial-out sequence.
 * Assumes sensor and line events are synchronous one-cycle pulses/levels
 * on ref_clk_in and that the voice player and dialer act on its pulses.
 */
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module alarm_dialout_sequencer
(
    // clock and reset
    input  wire logic                              ref_clk_in,
    input  wire logic                              rst_in,
    // register port
    input  wire logic [3:0]                        reg_addr_in,
    input  wire logic [15:0]                       reg_wdata_in,
    input  wire logic                              reg_wr_in,
    input  wire logic                              reg_rd_in,
    output logic      [15:0]                       reg_rdata_out,
    // sensor side
    input  wire logic                              sensor_abnormal_in,
    // line and voice side
    input  wire alarm_seq_pkg::line_ev_t           line_ev_in,
    output alarm_seq_pkg::line_cmd_t               line_cmd_out,
    output logic                                   speaker_on_out,
    // indicator
    output logic                                   led_green_out,
    output logic                                   led_red_out
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    alarm_seq_pkg::seq_state_t                state_q;
    logic [15:0]                              persist_q, predial_q, interdial_q;
    logic [7:0]                               repeat_q, maxcalls_q, numsel_q;
    logic                                     mute_q;
    logic                                     acked_q;
    logic [31:0]                              tick_cnt_q;
    logic                                     tick_q;
    logic [15:0]                              timer_q;
    logic [3:0]                               rings_q;
    logic [7:0]                               reps_q;
    logic [7:0]                               calls_q;
    logic [alarm_seq_pkg::SLOT_W-1:0]         slot_q;
    logic [3:0]                               blink_cnt_q;
    logic                                     blink_q;
    logic                                     ack_pulse;
    logic [alarm_seq_pkg::SLOT_W-1:0]         next_slot;
    logic [alarm_seq_pkg::SLOT_W-1:0]         first_slot;
    logic                                     call_limit_hit;

    assign ack_pulse = reg_wr_in && (reg_addr_in == alarm_seq_pkg::ADDR_CTRL)
                       && reg_wdata_in[alarm_seq_pkg::CTRL_ACK_BIT];

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // configuration storage; ack bit is a pulse and is not kept
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mute_q      <= 1'b0;
            persist_q   <= alarm_seq_pkg::PERSIST_RST;
            predial_q   <= alarm_seq_pkg::PREDIAL_RST;
            interdial_q <= alarm_seq_pkg::INTERDIAL_RST;
            repeat_q    <= alarm_seq_pkg::REPEAT_RST;
            maxcalls_q  <= alarm_seq_pkg::MAXCALLS_RST;
            numsel_q    <= alarm_seq_pkg::NUMSEL_RST;
        end
        else if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                alarm_seq_pkg::ADDR_CTRL:      mute_q      <= reg_wdata_in[alarm_seq_pkg::CTRL_MUTE_BIT];
                alarm_seq_pkg::ADDR_PERSIST:   persist_q   <= reg_wdata_in;
                alarm_seq_pkg::ADDR_PREDIAL:   predial_q   <= reg_wdata_in;
                alarm_seq_pkg::ADDR_INTERDIAL: interdial_q <= reg_wdata_in;
                alarm_seq_pkg::ADDR_REPEAT:    repeat_q    <= reg_wdata_in[7:0];
                alarm_seq_pkg::ADDR_MAXCALLS:  maxcalls_q  <= reg_wdata_in[7:0];
                alarm_seq_pkg::ADDR_NUMSEL:    numsel_q    <= reg_wdata_in[7:0];
                default:                       ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero for unmapped addresses
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                alarm_seq_pkg::ADDR_CTRL:      reg_rdata_out <= {15'h0000, mute_q};
                alarm_seq_pkg::ADDR_PERSIST:   reg_rdata_out <= persist_q;
                alarm_seq_pkg::ADDR_PREDIAL:   reg_rdata_out <= predial_q;
                alarm_seq_pkg::ADDR_INTERDIAL: reg_rdata_out <= interdial_q;
                alarm_seq_pkg::ADDR_REPEAT:    reg_rdata_out <= {8'h00, repeat_q};
                alarm_seq_pkg::ADDR_MAXCALLS:  reg_rdata_out <= {8'h00, maxcalls_q};
                alarm_seq_pkg::ADDR_NUMSEL:    reg_rdata_out <= {8'h00, numsel_q};
                alarm_seq_pkg::ADDR_STATUS:    reg_rdata_out <= {state_q, acked_q, slot_q, calls_q};
                default:                       reg_rdata_out <= 16'h0000;
            endcase
        end
        else
            reg_rdata_out <= 16'h0000;
    end

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------
    // one shared tick so every programmed interval uses the same unit
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b0;
        end
        else if (tick_cnt_q == 32'(alarm_seq_pkg::TICK_CYCLES - 1))
        begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q     <= 1'b0;
        end
    end

    // blink phase for the indicator
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            blink_cnt_q <= 4'h0;
            blink_q     <= 1'b0;
        end
        else if (tick_q)
        begin
            if (blink_cnt_q == 4'(alarm_seq_pkg::BLINK_TICKS - 1))
            begin
                blink_cnt_q <= 4'h0;
                blink_q     <= ~blink_q;
            end
            else
                blink_cnt_q <= blink_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // number selection
    // ------------------------------------------------------------------
    // next selected slot after slot_q, wrapping; first selected slot
    always_comb
    begin
        next_slot  = slot_q;
        first_slot = '0;
        for (int i = alarm_seq_pkg::NUM_SLOTS - 1; i >= 0; i--)
            if (numsel_q[i])
                first_slot = alarm_seq_pkg::SLOT_W'(i);
        for (int k = alarm_seq_pkg::NUM_SLOTS; k >= 1; k--)
            if (numsel_q[alarm_seq_pkg::SLOT_W'(32'(slot_q) + k)])
                next_slot = alarm_seq_pkg::SLOT_W'(32'(slot_q) + k);
    end

    assign call_limit_hit = (calls_q >= maxcalls_q);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // one state machine covers qualification, hold and dial-out
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= alarm_seq_pkg::ST_IDLE;
            timer_q <= 16'h0000;
            rings_q <= 4'h0;
            reps_q  <= 8'h00;
            calls_q <= 8'h00;
            slot_q  <= '0;
            acked_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                alarm_seq_pkg::ST_IDLE:
                    if (sensor_abnormal_in)
                    begin
                        state_q <= alarm_seq_pkg::ST_ALERT;
                        timer_q <= 16'h0000;
                        acked_q <= 1'b0;
                    end
                alarm_seq_pkg::ST_ALERT:
                    if (!sensor_abnormal_in)
                        state_q <= alarm_seq_pkg::ST_IDLE;
                    else if (timer_q >= persist_q)
                    begin
                        timer_q <= 16'h0000;
                        if (predial_q == 16'h0000)
                        begin
                            state_q <= alarm_seq_pkg::ST_DIAL;
                            slot_q  <= first_slot;
                            calls_q <= 8'h00;
                        end
                        else
                            state_q <= alarm_seq_pkg::ST_PREDIAL;
                    end
                    else if (tick_q)
                        timer_q <= timer_q + 16'h0001;
                alarm_seq_pkg::ST_PREDIAL:
                    if (ack_pulse)
                    begin
                        acked_q <= 1'b1;
                        state_q <= alarm_seq_pkg::ST_DONE;
                    end
                    else if (timer_q >= predial_q)
                    begin
                        state_q <= alarm_seq_pkg::ST_DIAL;
                        slot_q  <= first_slot;
                        calls_q <= 8'h00;
                    end
                    else if (tick_q)
                        timer_q <= timer_q + 16'h0001;
                alarm_seq_pkg::ST_DIAL:
                    if (call_limit_hit)
                    begin
                        acked_q <= 1'b1;
                        state_q <= alarm_seq_pkg::ST_DONE;
                    end
                    else
                    begin
                        calls_q <= calls_q + 8'h01;
                        rings_q <= 4'h0;
                        state_q <= alarm_seq_pkg::ST_RING;
                    end
                alarm_seq_pkg::ST_RING:
                    if (line_ev_in.answered)
                    begin
                        reps_q  <= 8'h00;
                        state_q <= (repeat_q == 8'h00) ? alarm_seq_pkg::ST_HANGUP
                                                       : alarm_seq_pkg::ST_RECITE;
                    end
                    else if (line_ev_in.busy)
                        state_q <= alarm_seq_pkg::ST_HANGUP;
                    else if (line_ev_in.ring)
                    begin
                        if (rings_q == alarm_seq_pkg::RING_LIMIT - 4'h1)
                            state_q <= alarm_seq_pkg::ST_HANGUP;
                        rings_q <= rings_q + 4'h1;
                    end
                alarm_seq_pkg::ST_RECITE:
                    if (line_ev_in.msg_done)
                    begin
                        reps_q <= reps_q + 8'h01;
                        if (reps_q + 8'h01 >= repeat_q)
                        begin
                            acked_q <= 1'b1;
                            state_q <= alarm_seq_pkg::ST_HANGUP;
                        end
                    end
                alarm_seq_pkg::ST_HANGUP:
                begin
                    timer_q <= 16'h0000;
                    state_q <= acked_q ? alarm_seq_pkg::ST_DONE : alarm_seq_pkg::ST_WAIT;
                end
                alarm_seq_pkg::ST_WAIT:
                    if (timer_q >= interdial_q)
                    begin
                        slot_q  <= next_slot;
                        state_q <= alarm_seq_pkg::ST_DIAL;
                    end
                    else if (tick_q)
                        timer_q <= timer_q + 16'h0001;
                alarm_seq_pkg::ST_DONE:
                    if (!sensor_abnormal_in)
                        state_q <= alarm_seq_pkg::ST_IDLE;
                default:
                    state_q <= alarm_seq_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // line, voice and indicator outputs
    // ------------------------------------------------------------------
    // line commands registered; dial and play are single-cycle pulses
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            line_cmd_out   <= '0;
            speaker_on_out <= 1'b0;
        end
        else
        begin
            line_cmd_out.off_hook <= (state_q == alarm_seq_pkg::ST_RING) ||
                                     (state_q == alarm_seq_pkg::ST_RECITE);
            line_cmd_out.dial     <= (state_q == alarm_seq_pkg::ST_DIAL) && !call_limit_hit;
            line_cmd_out.slot     <= slot_q;
            // first message on answer, then one more after each finished one until repeat_q are requested
            line_cmd_out.play_msg <= ((state_q == alarm_seq_pkg::ST_RING) && line_ev_in.answered
                                      && (repeat_q != 8'h00)) ||
                                     ((state_q == alarm_seq_pkg::ST_RECITE) && line_ev_in.msg_done
                                      && (reps_q + 8'h01 < repeat_q));
            line_cmd_out.ask_ack  <= (state_q == alarm_seq_pkg::ST_RECITE) && !acked_q;
            speaker_on_out        <= (state_q == alarm_seq_pkg::ST_PREDIAL) && !mute_q;
        end
    end

    // indicator: green steady idle, blinking green alert, blinking red pre-dial hold and dial-out, steady red done
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            led_green_out <= 1'b1;
            led_red_out   <= 1'b0;
        end
        else
        begin
            led_green_out <= (state_q == alarm_seq_pkg::ST_IDLE) ||
                             ((state_q == alarm_seq_pkg::ST_ALERT) && blink_q);
            led_red_out   <= (state_q == alarm_seq_pkg::ST_DONE) ||
                             ((state_q != alarm_seq_pkg::ST_IDLE) &&
                              (state_q != alarm_seq_pkg::ST_ALERT) && blink_q);
        end
    end

endmodule

// *** bench/alarm_seq_monitor.sv ***
/* Checker for the sequencer's line, speaker and green indicator outputs.
   Assumes one clock domain and the active-high async reset. */
`timescale 1ns/1ps
module alarm_seq_monitor
(
    // clock and reset
    input wire logic                     ref_clk_in,
    input wire logic                     rst_in,
    // observed ports
    input wire alarm_seq_pkg::line_ev_t  line_ev_in,
    input wire alarm_seq_pkg::line_cmd_t line_cmd_out,
    input wire logic                     speaker_on_out,
    input wire logic                     led_green_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // ------------------------------------------
    // call progress
    // ------------------------------------------
    // events count only while the line is held
    sequence s_busy;
        line_ev_in.busy && line_cmd_out.off_hook;
    endsequence
    sequence s_answer;
        line_ev_in.answered && line_cmd_out.off_hook;
    endsequence

    dial_pulse_a: assert property (line_cmd_out.dial |=> !line_cmd_out.dial)
        else $error("dial pulse too long");
    busy_hangup_a: assert property (s_busy |-> ##[1:3] !line_cmd_out.off_hook)
        else $error("no hang-up on busy");
    answer_recite_a: assert property (s_answer |-> ##[1:3] line_cmd_out.play_msg)
        else $error("no message on answer");
    answer_nodial_a: assert property (s_answer |=> (!line_cmd_out.dial) [*4])
        else $error("dial during answered call");
    play_pulse_a: assert property (line_cmd_out.play_msg |-> $past(line_cmd_out.off_hook) ##1 !line_cmd_out.play_msg)
        else $error("message request out of call");
    ask_held_a: assert property (line_cmd_out.ask_ack |-> line_cmd_out.off_hook)
        else $error("ack request on hook");
    red_dial_a: assert property (line_cmd_out.off_hook |-> !led_green_out)
        else $error("green lit during dial-out");
    speaker_call_a: assert property (line_cmd_out.dial |-> !speaker_on_out)
        else $error("speaker on while dialing");
endmodule

bind alarm_dialout_sequencer alarm_seq_monitor u_alarm_seq_monitor (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .line_ev_in(line_ev_in), .line_cmd_out(line_cmd_out), .speaker_on_out(speaker_on_out),
    .led_green_out(led_green_out));

// *** bench/line_partner.sv ***
/* Telephone line and voice player model for the sequencer bench.
   Assumes registered commands; mode picks answer, busy or no answer. */
`timescale 1ns/1ps
module line_partner
(
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    // 0 answer, 1 busy, 2 rings without answer
    input  wire logic [1:0]               mode_in,
    // line side of the sequencer
    input  wire alarm_seq_pkg::line_cmd_t cmd_in,
    output alarm_seq_pkg::line_ev_t       ev_out
);
    logic [7:0] hook_cnt_q;
    logic [3:0] msg_cnt_q;

    // time off hook, saturating so no second answer appears
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            hook_cnt_q <= 8'h00;
        else if (!cmd_in.off_hook)
            hook_cnt_q <= 8'h00;
        else if (hook_cnt_q != 8'hFF)
            hook_cnt_q <= hook_cnt_q + 8'h01;

    // one message lasts six cycles
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            msg_cnt_q <= 4'h0;
        else if (cmd_in.play_msg)
            msg_cnt_q <= 4'h6;
        else if (msg_cnt_q != 4'h0)
            msg_cnt_q <= msg_cnt_q - 4'h1;

    // rings come every 4 cycles while off hook, every cycle once hook_cnt_q saturates
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            ev_out <= '0;
        else
        begin
            ev_out.answered <= cmd_in.off_hook && mode_in == 2'h0 && hook_cnt_q == 8'h04;
            ev_out.busy     <= cmd_in.off_hook && mode_in == 2'h1 && hook_cnt_q == 8'h04;
            ev_out.ring     <= cmd_in.off_hook && mode_in == 2'h2 && hook_cnt_q[1:0] == 2'h3;
            ev_out.msg_done <= msg_cnt_q == 4'h1;
        end
endmodule

// *** bench/alarm_dialout_sequencer_bench.sv ***
/* Self-checking bench for the alarm dial-out sequencer.
   Assumes zero timers in sim: one base tick is far too long to wait. */
`timescale 1ns/1ps
module alarm_dialout_sequencer_bench;
    logic ref_clk_in, rst_in, reg_wr_in, reg_rd_in, sensor_abnormal_in;
    logic [3:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, rd;
    alarm_seq_pkg::line_ev_t line_ev_in;
    alarm_seq_pkg::line_cmd_t line_cmd_out;
    logic speaker_on_out, led_green_out, led_red_out;
    logic [1:0] line_mode;
    logic [2:0] slots[$];
    int plays, rings, bad_count, checked;

    alarm_dialout_sequencer u_alarm_dialout_sequencer (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .sensor_abnormal_in(sensor_abnormal_in), .line_ev_in(line_ev_in),
        .line_cmd_out(line_cmd_out), .speaker_on_out(speaker_on_out), .led_green_out(led_green_out),
        .led_red_out(led_red_out));
    line_partner u_line_partner (.clk_in(ref_clk_in), .rst_in(rst_in), .mode_in(line_mode),
        .cmd_in(line_cmd_out), .ev_out(line_ev_in));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    // call log: dialed slots, message requests, rings of the last call
    always @(posedge ref_clk_in)
    begin
        if (line_cmd_out.dial)
        begin
            slots.push_back(line_cmd_out.slot);
            rings = 0;
        end
        plays += line_cmd_out.play_msg;
        rings += line_ev_in.ring;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdr(input logic [3:0] a);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        rd = reg_rdata_out;
    endtask
    // fresh reset, zero timers, then raise the sensor and poll status
    task automatic setup(input logic [1:0] m, input logic [7:0] sel, input logic [7:0] lim, input logic [7:0] rep);
        @(posedge ref_clk_in);
        sensor_abnormal_in <= 1'b0;
        line_mode <= m;
        rst_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        slots.delete();
        plays = 0;
        wr(alarm_seq_pkg::ADDR_PERSIST, 16'h0000);
        wr(alarm_seq_pkg::ADDR_PREDIAL, 16'h0000);
        wr(alarm_seq_pkg::ADDR_INTERDIAL, 16'h0000);
        wr(alarm_seq_pkg::ADDR_REPEAT, {8'h00, rep});
        wr(alarm_seq_pkg::ADDR_MAXCALLS, {8'h00, lim});
        wr(alarm_seq_pkg::ADDR_NUMSEL, {8'h00, sel});
        sensor_abnormal_in <= 1'b1;
        rd = 16'h0000;
        for (int i = 0; i < 3000 && rd[11] !== 1'b1; i++)
            rdr(alarm_seq_pkg::ADDR_STATUS);
        chk({15'h0000, rd[11]}, 16'h0001);
    endtask

    task automatic t_regs();
        rdr(alarm_seq_pkg::ADDR_PERSIST);
        chk(rd, alarm_seq_pkg::PERSIST_RST);
        rdr(alarm_seq_pkg::ADDR_REPEAT);
        chk(rd, 16'h0003);
        rdr(4'h8);
        chk(rd, 16'h0000);
        wr(alarm_seq_pkg::ADDR_STATUS, 16'hFFFF);
        rdr(alarm_seq_pkg::ADDR_STATUS);
        chk(rd, 16'h0000);
    endtask
    task automatic t_answer();
        setup(2'h0, 8'h06, 8'h04, 8'h02);
        chk({13'h0000, slots[0]}, 16'h0001);
        chk(16'(plays), 16'h0002);
        chk(16'(slots.size()), 16'h0001);
    endtask
    task automatic t_busy();
        setup(2'h1, 8'h06, 8'h03, 8'h01);
        chk({7'h00, slots[0], slots[1], slots[2]}, {7'h00, 3'h1, 3'h2, 3'h1});
        chk(16'(slots.size()), 16'h0003);
        chk({8'h00, rd[7:0]}, 16'h0003);
    endtask
    task automatic t_ring();
        setup(2'h2, 8'h01, 8'h01, 8'h01);
        chk(16'(rings), 16'h000A);
        chk(16'(slots.size()), 16'h0001);
        sensor_abnormal_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        rdr(alarm_seq_pkg::ADDR_STATUS);
        chk({12'h000, rd[15:12]}, 16'h0000);
    endtask
    // nonzero hold: one tick outlasts the run, so the on-site ack always wins
    task automatic t_hold();
        slots.delete();
        wr(alarm_seq_pkg::ADDR_PREDIAL, 16'h0001);
        sensor_abnormal_in <= 1'b1;
        @(negedge ref_clk_in);
        chk({14'h0000, led_green_out, led_red_out}, 16'h0002);
        repeat (4) @(negedge ref_clk_in);
        chk({14'h0000, speaker_on_out, led_green_out}, 16'h0002);
        chk(16'(slots.size()), 16'h0000);
        wr(alarm_seq_pkg::ADDR_CTRL, 16'h0001);
        repeat (2) @(negedge ref_clk_in);
        chk({15'h0000, speaker_on_out}, 16'h0000);
        wr(alarm_seq_pkg::ADDR_CTRL, 16'h0003);
        rdr(alarm_seq_pkg::ADDR_STATUS);
        chk({11'h000, rd[15:11]}, {11'h000, alarm_seq_pkg::ST_DONE, 1'b1});
        chk({14'h0000, led_green_out, led_red_out}, 16'h0001);
        chk(16'(slots.size()), 16'h0000);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        {rst_in, reg_wr_in, reg_rd_in, sensor_abnormal_in} = 4'h8;
        {reg_addr_in, reg_wdata_in, line_mode} = '0;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_answer();
        t_busy();
        t_ring();
        t_hold();
        test_done();
    end

    // hang guard: the scenarios take a few hundred cycles
    initial
    begin
        #(25 * 60000);
        bad_count++;
        test_done();
    end
endmodule
